// File: ovins_dev.sv
// Device end: Z3/Z4 source select, overhead port clock and serial capture
// Functional notes
// - Z3 select one: take Z3 from serial port
// - Z3 select zero: insert Z3 value register
// - Z4 select zero: insert Z4 value register
// - Z4 select one: take Z4 from serial port
// - Z4 value register: 8 bits, RW, resets zero
// - External logic samples enable, frame on rising edges
// - Both high seen: external waits 48 periods
// - Then MSB driven on next falling edge
// - Device captures each bit on following rising edge
// - Remaining seven bits on next seven falling edges
// - After eighth bit (sixteenth when z4_follow is set), external resumes monitoring strobes
// - Serial slot aligned with seventh overhead byte
// - Insert request need not be driven
// - Control bits 7 to 4 read zero
`timescale 1ns/1ps
`include "ovins_map.svh"

module ovins_dev (
	// System
	input wire logic clk_sys,
	input wire logic srst,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Overhead link
	ovins_link_if.dev link,
	// Bytes for the outbound SPE
	output logic [7:0] z3_insert_byte,
	output logic [7:0] z4_insert_byte,
	output logic spe_start_pulse
);

	// ****************************************
	// Declarations
	// ****************************************
	logic [3:0] ctrl_r;
	logic [3:0] ctrl_nxt;
	logic [7:0] z3_val_r;
	logic [7:0] z3_val_nxt;
	logic [7:0] z4_val_r;
	logic [7:0] z4_val_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic ack_r;
	logic ack_nxt;
	logic [3:0] ph_r;
	logic [3:0] ph_nxt;
	logic oclk_r;
	logic oclk_nxt;
	logic strb_r;
	logic strb_nxt;
	logic [6:0] pcnt_r;
	logic [6:0] pcnt_nxt;
	logic [6:0] sh_r;
	logic [6:0] sh_nxt;
	logic [7:0] z3_cap_r;
	logic [7:0] z3_cap_nxt;
	logic [7:0] z4_cap_r;
	logic [7:0] z4_cap_nxt;
	logic [7:0] z3_ins_r;
	logic [7:0] z3_ins_nxt;
	logic [7:0] z4_ins_r;
	logic [7:0] z4_ins_nxt;
	logic spe_r;
	logic spe_nxt;
	logic [13:0] idx;
	logic req;
	logic wr;
	logic rise;
	logic fall;
	logic ser_s;
	logic insreq_s;

	// ****************************************
	// Slot decode
	// ****************************************
	function automatic logic in_slot(input logic [6:0] pos, input logic [6:0] first);
		in_slot = (pos >= first) && (pos < first + `OVINS_BYTE_SPAN);
	endfunction

	// ****************************************
	// Pin synchroniser
	// ****************************************
	ovins_sync #(
		.WIDTH(2)
	) u_sync (
		.clk_sys(clk_sys),
		.srst(srst),
		.async_in({link.overhead_insert_request_in, link.overhead_serial_in}),
		.sync_out({insreq_s, ser_s})
	);

	// ****************************************
	// Register bus
	// ****************************************
	always_comb begin
		idx = wb_adr_i[15:2];
		req = wb_cyc_i & wb_stb_i & ~ack_r;
		wr = wb_cyc_i & wb_stb_i & ack_r & wb_we_i & wb_sel_i[0];
		ack_nxt = req;
		ctrl_nxt = ctrl_r;
		z3_val_nxt = z3_val_r;
		z4_val_nxt = z4_val_r;
		rdata_nxt = rdata_r;
		if (req) begin
			unique case (idx)
				`OVINS_IDX_CTRL: begin
					rdata_nxt = {28'h0000000, ctrl_r};
				end
				`OVINS_IDX_Z3: begin
					rdata_nxt = {24'h000000, z3_val_r};
				end
				`OVINS_IDX_Z4: begin
					rdata_nxt = {24'h000000, z4_val_r};
				end
				`OVINS_IDX_STAT: begin
					rdata_nxt = {15'h0000, insreq_s, z4_cap_r, z3_cap_r};
				end
				default: begin
					rdata_nxt = 32'h00000000;
				end
			endcase
		end
		if (wr) begin
			unique case (idx)
				`OVINS_IDX_CTRL: begin
					ctrl_nxt = wb_dat_i[3:0];
				end
				`OVINS_IDX_Z3: begin
					z3_val_nxt = wb_dat_i[7:0];
				end
				`OVINS_IDX_Z4: begin
					z4_val_nxt = wb_dat_i[7:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ctrl_r <= `OVINS_CTRL_RST;
			z3_val_r <= `OVINS_Z3_RST;
			z4_val_r <= `OVINS_Z4_RST;
			rdata_r <= 32'h00000000;
			ack_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			z3_val_r <= z3_val_nxt;
			z4_val_r <= z4_val_nxt;
			rdata_r <= rdata_nxt;
			ack_r <= ack_nxt;
		end
	end

	// ****************************************
	// Overhead port clock and frame position
	// ****************************************
	always_comb begin
		rise = (ph_r == `OVINS_DIV_LAST);
		fall = (ph_r == `OVINS_DIV_FALL);
		ph_nxt = rise ? 4'h0 : ph_r + 4'h1;
		oclk_nxt = (ph_nxt < `OVINS_DIV_HALF);
		pcnt_nxt = pcnt_r;
		if (rise) begin
			pcnt_nxt = (pcnt_r == `OVINS_FRAME_LAST) ? 7'h00 : pcnt_r + 7'h01;
		end
		strb_nxt = strb_r;
		if (fall) begin
			strb_nxt = (pcnt_r == `OVINS_FRAME_LAST);
		end
		spe_nxt = rise && (pcnt_r == `OVINS_FRAME_LAST);
	end

	// ****************************************
	// Serial capture and source select
	// ****************************************
	always_comb begin
		sh_nxt = sh_r;
		z3_cap_nxt = z3_cap_r;
		z4_cap_nxt = z4_cap_r;
		if (rise && (in_slot(pcnt_nxt, `OVINS_Z3_FIRST) || in_slot(pcnt_nxt, `OVINS_Z4_FIRST))) begin
			sh_nxt = {sh_r[5:0], ser_s};
			if (pcnt_nxt == `OVINS_Z3_LAST) begin
				z3_cap_nxt = {sh_r, ser_s};
			end
			if (pcnt_nxt == `OVINS_Z4_LAST) begin
				z4_cap_nxt = {sh_r, ser_s};
			end
		end
		z3_ins_nxt = ctrl_r[`OVINS_BIT_Z3] ? z3_cap_r : z3_val_r;
		z4_ins_nxt = ctrl_r[`OVINS_BIT_Z4] ? z4_cap_r : z4_val_r;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			// Start in the low phase so the first high phase is full width
			ph_r <= `OVINS_DIV_HALF;
			oclk_r <= 1'b0;
			strb_r <= 1'b0;
			pcnt_r <= 7'h00;
			spe_r <= 1'b0;
			sh_r <= 7'h00;
			z3_cap_r <= 8'h00;
			z4_cap_r <= 8'h00;
			z3_ins_r <= 8'h00;
			z4_ins_r <= 8'h00;
		end else begin
			ph_r <= ph_nxt;
			oclk_r <= oclk_nxt;
			strb_r <= strb_nxt;
			pcnt_r <= pcnt_nxt;
			spe_r <= spe_nxt;
			sh_r <= sh_nxt;
			z3_cap_r <= z3_cap_nxt;
			z4_cap_r <= z4_cap_nxt;
			z3_ins_r <= z3_ins_nxt;
			z4_ins_r <= z4_ins_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign wb_dat_o = rdata_r;
	assign wb_ack_o = ack_r;
	assign link.overhead_port_clock_out = oclk_r;
	assign link.overhead_slot_enable_out = strb_r;
	assign link.overhead_frame_strobe_out = strb_r;
	assign z3_insert_byte = z3_ins_r;
	assign z4_insert_byte = z4_ins_r;
	assign spe_start_pulse = spe_r;
endmodule

// File: ovins_ext.sv
// External end: watches the strobes and shifts Z3 (and Z4) in MSB first
`timescale 1ns/1ps
`include "ovins_map.svh"

module ovins_ext (
	// System
	input wire logic clk_sys,
	input wire logic srst,
	// Overhead link
	ovins_link_if.ext link,
	// Bytes to supply
	input wire logic [7:0] z3_byte,
	input wire logic [7:0] z4_byte,
	input wire logic z4_follow,
	output logic busy
);

	// ****************************************
	// Declarations
	// ****************************************
	ovins_pkg::ovins_ext_state_type st_r;
	ovins_pkg::ovins_ext_state_type st_nxt;
	logic [6:0] cnt_r;
	logic [6:0] cnt_nxt;
	logic [4:0] bit_r;
	logic [4:0] bit_nxt;
	logic [4:0] last_r;
	logic [4:0] last_nxt;
	logic [15:0] sh_r;
	logic [15:0] sh_nxt;
	logic ser_r;
	logic ser_nxt;
	logic busy_r;
	logic busy_nxt;
	logic clk_d_r;
	logic clk_s;
	logic en_s;
	logic frm_s;
	logic rise;
	logic fall;

	// ****************************************
	// Pin synchroniser
	// ****************************************
	ovins_sync #(
		.WIDTH(3)
	) u_sync (
		.clk_sys(clk_sys),
		.srst(srst),
		.async_in({link.overhead_port_clock_out, link.overhead_slot_enable_out,
			link.overhead_frame_strobe_out}),
		.sync_out({clk_s, en_s, frm_s})
	);

	// ****************************************
	// Shifter
	// ****************************************
	always_comb begin
		rise = clk_s & ~clk_d_r;
		fall = ~clk_s & clk_d_r;
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		bit_nxt = bit_r;
		last_nxt = last_r;
		sh_nxt = sh_r;
		ser_nxt = ser_r;
		unique case (st_r)
			ovins_pkg::EXT_IDLE: begin
				if (rise && en_s && frm_s) begin
					st_nxt = ovins_pkg::EXT_WAIT;
					cnt_nxt = 7'h00;
					sh_nxt = {z3_byte, z4_byte};
					last_nxt = z4_follow ? `OVINS_BITS_TWO : `OVINS_BITS_ONE;
				end
			end
			ovins_pkg::EXT_WAIT: begin
				if (rise) begin
					if (cnt_r == `OVINS_WAIT_LAST) begin
						st_nxt = ovins_pkg::EXT_SHIFT;
						bit_nxt = 5'h00;
					end else begin
						cnt_nxt = cnt_r + 7'h01;
					end
				end
			end
			ovins_pkg::EXT_SHIFT: begin
				if (fall) begin
					ser_nxt = sh_r[15];
					sh_nxt = {sh_r[14:0], 1'b0};
					bit_nxt = bit_r + 5'h01;
					if (bit_r == last_r) begin
						st_nxt = ovins_pkg::EXT_IDLE;
					end
				end
			end
		endcase
		busy_nxt = (st_nxt != ovins_pkg::EXT_IDLE);
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_r <= ovins_pkg::EXT_IDLE;
			cnt_r <= 7'h00;
			bit_r <= 5'h00;
			last_r <= `OVINS_BITS_ONE;
			sh_r <= 16'h0000;
			ser_r <= 1'b0;
			busy_r <= 1'b0;
			clk_d_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			bit_r <= bit_nxt;
			last_r <= last_nxt;
			sh_r <= sh_nxt;
			ser_r <= ser_nxt;
			busy_r <= busy_nxt;
			clk_d_r <= clk_s;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign link.overhead_serial_in = ser_r;
	assign link.overhead_insert_request_in = 1'b0;
	assign busy = busy_r;
endmodule

// File: ovins_link_if.sv
// Serial overhead insertion link between device and external logic
`timescale 1ns/1ps

interface ovins_link_if;
	logic overhead_port_clock_out;
	logic overhead_slot_enable_out;
	logic overhead_frame_strobe_out;
	logic overhead_serial_in;
	logic overhead_insert_request_in;

	modport dev (
		output overhead_port_clock_out,
		output overhead_slot_enable_out,
		output overhead_frame_strobe_out,
		input overhead_serial_in,
		input overhead_insert_request_in
	);

	modport ext (
		input overhead_port_clock_out,
		input overhead_slot_enable_out,
		input overhead_frame_strobe_out,
		output overhead_serial_in,
		output overhead_insert_request_in
	);
endinterface

// File: ovins_link_props.sv
// Concurrent checks on the overhead insertion link
`timescale 1ns/1ps

module ovins_link_props (
	// System
	input wire logic clk_sys,
	input wire logic srst,
	// Link
	input wire logic overhead_port_clock_out,
	input wire logic overhead_slot_enable_out,
	input wire logic overhead_frame_strobe_out,
	input wire logic overhead_serial_in,
	input wire logic overhead_insert_request_in
);
	// ****************************************
	// Period and frame counters
	// ****************************************
	wire ck = overhead_port_clock_out;
	wire en = overhead_slot_enable_out;
	wire sd = overhead_serial_in;
	logic ck_q_r, ck_q_nxt, en_q_r, en_q_nxt;
	logic [7:0] p_r, p_nxt;
	logic [11:0] g_r, g_nxt;
	always_comb begin
		ck_q_nxt = ck;
		en_q_nxt = en;
		p_nxt = p_r;
		g_nxt = (g_r == 12'hFFF) ? g_r : g_r + 12'h001;
		if (ck && !ck_q_r) begin
			p_nxt = en ? 8'h00 : ((p_r == 8'hFF) ? p_r : p_r + 8'h01);
		end
		if (en && !en_q_r) begin
			g_nxt = 12'h000;
		end
		if (srst) begin
			p_nxt = 8'hFF;
			g_nxt = 12'hFFF;
		end
	end
	always_ff @(posedge clk_sys) begin
		ck_q_r <= ck_q_nxt;
		en_q_r <= en_q_nxt;
		p_r <= p_nxt;
		g_r <= g_nxt;
	end
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	sequence s_high;
		ck [*8] ##1 !ck;
	endsequence
	sequence s_low;
		!ck [*8] ##1 ck;
	endsequence
	chk_clk_high_phase: assert property ($rose(ck) |-> s_high)
		else $error("port clock high phase wrong");
	chk_clk_low_phase: assert property ($fell(ck) |-> s_low)
		else $error("port clock low phase wrong");
	chk_strobe_pair: assert property (en == overhead_frame_strobe_out)
		else $error("enable and frame differ");
	chk_strobe_at_low: assert property ($rose(en) |-> !ck)
		else $error("strobe rose while clock high");
	chk_strobe_width: assert property ($rose(en) |-> en [*8] ##9 $fell(en))
		else $error("strobe width wrong");
	chk_frame_gap: assert property (en && !en_q_r && g_r != 12'hFFF |-> g_r == 12'h7FF)
		else $error("frame spacing wrong");
	chk_serial_slot: assert property ($changed(sd) |-> p_r >= 8'h30 && p_r <= 8'h40)
		else $error("serial bit outside slot");
	chk_serial_on_low: assert property ($changed(sd) |-> !ck)
		else $error("serial bit changed while clock high");
	chk_request_idle: assert property (!overhead_insert_request_in)
		else $error("insert request driven");
endmodule

// File: ovins_map.svh
// Register indexes, field positions, reset values and link timing counts
`ifndef OVINS_MAP_SVH
`define OVINS_MAP_SVH

// ****************************************
// Register indexes (byte address = 4 * index)
// ****************************************
`define OVINS_IDX_CTRL 14'h1982
`define OVINS_IDX_Z3 14'h19AB
`define OVINS_IDX_Z4 14'h19AF
`define OVINS_IDX_STAT 14'h19C0

// ****************************************
// Control field positions and reset values
// ****************************************
`define OVINS_BIT_H4 0
`define OVINS_BIT_Z3 1
`define OVINS_BIT_Z4 2
`define OVINS_BIT_Z5 3
`define OVINS_CTRL_RST 4'h0
`define OVINS_Z3_RST 8'h00
`define OVINS_Z4_RST 8'h00
`define OVINS_STAT_REQ_BIT 16

// ****************************************
// Link timing counts
// ****************************************
`define OVINS_DIV_LAST 4'hF
`define OVINS_DIV_FALL 4'h7
`define OVINS_DIV_HALF 4'h8
`define OVINS_FRAME_LAST 7'h7F
`define OVINS_Z3_WAIT 7'h30
`define OVINS_Z3_FIRST 7'h31
`define OVINS_Z4_FIRST 7'h39
`define OVINS_BYTE_SPAN 7'h08
`define OVINS_Z3_LAST 7'h38
`define OVINS_Z4_LAST 7'h40
`define OVINS_WAIT_LAST 7'h2F
`define OVINS_BITS_ONE 5'h07
`define OVINS_BITS_TWO 5'h0F

`endif

// File: ovins_pkg.sv
// Types used by the external end of the overhead insertion link
package ovins_pkg;

	// ****************************************
	// External shifter states
	// ****************************************
	typedef enum logic [2:0] {
		EXT_IDLE = 3'h1,
		EXT_WAIT = 3'h2,
		EXT_SHIFT = 3'h4
	} ovins_ext_state_type;

endpackage

// File: ovins_sync.sv
// Two-flop synchroniser for signals from outside the clk_sys domain
`timescale 1ns/1ps

module ovins_sync #(
	parameter int WIDTH = 2
) (
	// System
	input wire logic clk_sys,
	input wire logic srst,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_nxt;

	always_comb begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_out = sync_r;
endmodule

// File: ovins_tb.sv
// Testbench for the overhead insertion link
`timescale 1ns/1ps
`include "ovins_map.svh"

module ovins_tb;
	logic clk_sys = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, z4f = 1'b0;
	logic [3:0] sel = 4'h0;
	logic [15:0] adr = 16'h0000;
	logic [31:0] dat = 32'h0, rdat, wdo;
	logic ack, busy, spe;
	logic [7:0] z3i, z4i, v3, v4, z3b = 8'h00, z4b = 8'h00;
	int fail_count = 0, n_checks = 0, i;
	ovins_link_if link ();
	ovins_dev ovins_dev_i (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(wdo),
		.wb_ack_o(ack), .link(link), .z3_insert_byte(z3i), .z4_insert_byte(z4i),
		.spe_start_pulse(spe));
	ovins_ext ovins_ext_i (.clk_sys(clk_sys), .srst(srst), .link(link), .z3_byte(z3b),
		.z4_byte(z4b), .z4_follow(z4f), .busy(busy));
	ovins_link_props ovins_link_props_i (.clk_sys(clk_sys), .srst(srst),
		.overhead_port_clock_out(link.overhead_port_clock_out),
		.overhead_slot_enable_out(link.overhead_slot_enable_out),
		.overhead_frame_strobe_out(link.overhead_frame_strobe_out),
		.overhead_serial_in(link.overhead_serial_in),
		.overhead_insert_request_in(link.overhead_insert_request_in));
	initial begin
		forever #4 clk_sys = ~clk_sys;
	end
	// ****************************************
	// Tasks and expectations
	// ****************************************
	task close_out();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask
	task wb(input logic w, input logic [3:0] s, input logic [13:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= s;
		adr <= {a, 2'h0};
		dat <= d;
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack !== 1'b1 && n < 100);
		if (ack !== 1'b1) begin
			fail_count++;
			close_out();
		end
		rdat = wdo;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_sys);
	endtask
	task rd_chk(input logic [13:0] a, input logic [31:0] e);
		wb(1'b0, 4'hF, a, 32'h0);
		chk(rdat, e);
	endtask
	task wt(input logic k, input logic v);
		int n;
		for (n = 0; n < 3000 && (k ? busy : spe) !== v; n++) begin
			@(posedge clk_sys);
		end
		if ((k ? busy : spe) !== v) begin
			fail_count++;
			close_out();
		end
	endtask
	function logic [31:0] exp_ctrl(input logic [31:0] d);
		return {28'h0000000, d[3:0]};
	endfunction
	function logic [31:0] exp_stat(input logic [7:0] a, input logic [7:0] b);
		return {16'h0000, b, a};
	endfunction
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		void'($urandom(32'h1eac));
		repeat (12) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		rd_chk(`OVINS_IDX_CTRL, 32'h0);
		rd_chk(`OVINS_IDX_Z4, 32'h0);
		rd_chk(`OVINS_IDX_Z3, 32'h0);
		rd_chk(14'h0001, 32'h0);
		wb(1'b1, 4'hF, `OVINS_IDX_CTRL, 32'hFF);
		rd_chk(`OVINS_IDX_CTRL, exp_ctrl(32'hFF));
		wb(1'b1, 4'hE, `OVINS_IDX_Z4, 32'h5A);
		rd_chk(`OVINS_IDX_Z4, 32'h0);
		for (i = 0; i < 3; i++) begin
			v3 = 8'($urandom);
			v4 = 8'($urandom);
			wb(1'b1, 4'hF, `OVINS_IDX_CTRL, 32'h0);
			wb(1'b1, 4'hF, `OVINS_IDX_Z3, {24'h0, v3});
			wb(1'b1, 4'hF, `OVINS_IDX_Z4, {24'h0, v4});
			repeat (2) @(posedge clk_sys);
			chk({24'h0, z3i}, {24'h0, v3});
			chk({24'h0, z4i}, {24'h0, v4});
			rd_chk(`OVINS_IDX_Z4, {24'h0, v4});
		end
		for (i = 0; i < 4; i++) begin
			wt(1'b1, 1'b0);
			z3b <= (i == 0) ? 8'h80 : 8'($urandom);
			z4b <= (i == 0) ? 8'h01 : 8'($urandom);
			z4f <= !i[0];
			wb(1'b1, 4'hF, `OVINS_IDX_CTRL, i[0] ? 32'h2 : 32'h6);
			wt(1'b0, 1'b1);
			wt(1'b1, 1'b1);
			wt(1'b1, 1'b0);
			repeat (24) @(posedge clk_sys);
			chk({24'h0, z3i}, {24'h0, z3b});
			chk({24'h0, z4i}, {24'h0, i[0] ? v4 : z4b});
			if (!i[0]) begin
				rd_chk(`OVINS_IDX_STAT, exp_stat(z3b, z4b));
			end
		end
		close_out();
	end
endmodule
